// ===== common/pldl_regs.vh
// register map, field positions, reset values and settings of the lock detect block
// Overview of operation
// R1: lock flag rises after a selected run of consecutive good comparator cycles.
// R2: once locked, one cycle beyond the unlock window drops lock at once.
// R3: unlock window is wider than lock window so small excess error won't chatter.
// R4: window widths come from range bit, antibacklash field and count setting; the code takes them from range bit and antibacklash field only.
// R5: lock flag selectable on indicator, status and reference monitor pins.
// R6: software keeps comparator period longer than the unlock window.
// R7: charged mode sources current while locked, shorts pin to ground otherwise.
// R8: software selects charged mode with code 0x04 and enables the pin comparator.
// R9: pin comparator output selectable on reference monitor or status pin.
// R10: gated clock outputs are enabled only while the charged indicator is high.
// R11: two pulsed modes: n-channel idles high, p-channel idles low.
// R12: very low bandwidth loops should use charged mode with a capacitor.
// R13: holdover samples the logic level of the lock indicator pin.
// R14: count field zero means five good cycles are needed.
// R15: with comparator disabled, holdover sees the pin level as high.
// R16: reset clears counter and flag; a bad cycle before lock clears counter.
`ifndef PLDL_REGS_VH
`define PLDL_REGS_VH
// register indices; byte address is four times the index
`define PLDL_IDX_STATUS_PIN 10'h017
`define PLDL_IDX_LOCK_CFG 10'h018
`define PLDL_IDX_LOCK_PIN 10'h01A
`define PLDL_IDX_REFERENCE_MONITOR_PIN_PIN 10'h01B
`define PLDL_IDX_COMP_CTRL 10'h01D
`define PLDL_IDX_GATE_LO 10'h0FC
`define PLDL_IDX_GATE_HI 10'h0FD
`define PLDL_IDX_IRQ_STAT 10'h100
`define PLDL_IDX_IRQ_MASK 10'h101
`define PLDL_IDX_LIVE 10'h102
// fields
`define PLDL_ABP_LSB 0
`define PLDL_STATUS_SEL_LSB 2
`define PLDL_WIN_BIT 4
`define PLDL_CNT_LSB 5
`define PLDL_COMP_EN_BIT 3
// reset values
`define PLDL_RST_STATUS_PIN 8'h00
`define PLDL_RST_LOCK_CFG 8'h00
`define PLDL_RST_LOCK_PIN 6'h00
`define PLDL_RST_REFERENCE_MONITOR_PIN_PIN 5'h00
`define PLDL_RST_COMP_CTRL 8'h00
// lock indicator pin modes
`define PLDL_LD_FLAG 6'h01
`define PLDL_LD_NCH 6'h02
`define PLDL_LD_PCH 6'h03
`define PLDL_LD_CHARGED 6'h04
// status and reference monitor pin selections
`define PLDL_STS_FLAG 6'h01
`define PLDL_STS_COMP 6'h02
`define PLDL_RMN_FLAG 5'h01
`define PLDL_RMN_COMP 5'h02
// good-cycle counts per count field value
`define PLDL_CNT_0 8'h05
`define PLDL_CNT_1 8'h10
`define PLDL_CNT_2 8'h40
`define PLDL_CNT_3 8'hFF
// lock thresholds in phase error units per antibacklash setting, high range
`define PLDL_THR_0 8'h10
`define PLDL_THR_1 8'h08
`define PLDL_THR_2 8'h20
`define PLDL_THR_3 8'h10
// interrupt bits
`define PLDL_EV_LOCK 0
`define PLDL_EV_UNLOCK 1
`define PLDL_EV_COMP 2
`define PLDL_EV_W 3
`endif

// ===== verilog/pldl_lock_detect.v
// lock detect logic with wishbone register slave
//
// Design decisions made here: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "pldl_regs.vh"
module pldl_lock_detect (
  input wire ref_clk,
  input wire reset_n,
  // wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [11:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // phase edge comparator result, one strobe per comparator cycle
  input wire phase_edge_comparator_strobe,
  input wire [7:0] phase_edge_comparator_error,
  // lock indicator pin
  input wire lock_indicator_pin_i,
  output reg lock_indicator_pin_o,
  output reg lock_indicator_pin_oe,
  output wire lock_indicator_source_en,
  input wire lock_pin_comparator_i,
  output wire status_pin,
  output wire reference_monitor_pin,
  output wire holdover_lock_sense,
  input wire [15:0] clk_out_request,
  output wire [15:0] clk_out_enable,
  output wire phase_lock_flag,
  output wire irq
);

  // ****************************************
  // registers
  // ****************************************
  reg [7:0] status_pin_r;
  reg [7:0] lock_cfg_r;
  reg [5:0] lock_pin_r;
  reg [4:0] reference_monitor_pin_pin_r;
  reg [7:0] comp_ctrl_r;
  reg [15:0] gate_r;
  reg [`PLDL_EV_W-1:0] irq_stat_r;
  reg [`PLDL_EV_W-1:0] irq_mask_r;
  reg lock_r;
  reg [7:0] good_cnt_r;
  reg pulse_r;
  reg comp_q_r;

  wire [9:0] idx;
  wire req;
  wire wr;
  wire comp_en;
  wire comp_level;
  assign idx = wb_adr_i[11:2];
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr = req & wb_we_i & wb_sel_i[0];
  assign comp_en = comp_ctrl_r[`PLDL_COMP_EN_BIT];
  assign comp_level = comp_en & lock_pin_comparator_i;

  // ****************************************
  // lock windows
  // ****************************************
  reg [7:0] need_cnt;
  reg [7:0] lock_thr;
  wire [8:0] unlock_thr;
  always @* begin
    case (lock_cfg_r[`PLDL_CNT_LSB+1:`PLDL_CNT_LSB])
      2'b00: need_cnt = `PLDL_CNT_0; // [R14]
      2'b01: need_cnt = `PLDL_CNT_1; // [R1]
      2'b10: need_cnt = `PLDL_CNT_2;
      default: need_cnt = `PLDL_CNT_3;
    endcase
    case (status_pin_r[`PLDL_ABP_LSB+1:`PLDL_ABP_LSB])
      2'b00: lock_thr = `PLDL_THR_0; // [R4]
      2'b01: lock_thr = `PLDL_THR_1;
      2'b10: lock_thr = `PLDL_THR_2;
      default: lock_thr = `PLDL_THR_3;
    endcase
    // low range halves the window
    if (lock_cfg_r[`PLDL_WIN_BIT]) begin
      lock_thr = {1'b0, lock_thr[7:1]}; // [R4]
    end
  end
  // unlock window is twice the lock window so it is always the wider one
  assign unlock_thr = {lock_thr, 1'b0}; // [R3]

  // ****************************************
  // digital lock detector
  // ****************************************
  wire good_cyc;
  wire bad_cyc;
  wire lock_set;
  wire lock_clr;
  assign good_cyc = phase_edge_comparator_error < lock_thr;
  assign bad_cyc = {1'b0, phase_edge_comparator_error} > unlock_thr;
  assign lock_set = phase_edge_comparator_strobe & ~lock_r & good_cyc &
    (good_cnt_r + 8'h01 >= need_cnt);
  assign lock_clr = phase_edge_comparator_strobe & lock_r & bad_cyc;

  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      lock_r <= 1'b0; // [R16]
      good_cnt_r <= 8'h00;
    end else if (phase_edge_comparator_strobe) begin
      if (lock_r) begin
        if (bad_cyc) begin
          lock_r <= 1'b0; // [R2]
          good_cnt_r <= 8'h00;
        end
      end else if (!good_cyc) begin
        good_cnt_r <= 8'h00; // [R16]
      end else if (lock_set) begin
        lock_r <= 1'b1; // [R1]
        good_cnt_r <= 8'h00;
      end else begin
        good_cnt_r <= good_cnt_r + 8'h01; // [R1]
      end
    end
  end
  assign phase_lock_flag = lock_r;

  // ****************************************
  // lock indicator pin
  // ****************************************
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      pulse_r <= 1'b0;
    end else begin
      // one clock pulse for each comparator cycle outside the lock window
      pulse_r <= phase_edge_comparator_strobe & ~good_cyc;
    end
  end

  always @* begin
    lock_indicator_pin_o = 1'b0;
    lock_indicator_pin_oe = 1'b0;
    case (lock_pin_r)
      `PLDL_LD_FLAG: begin
        lock_indicator_pin_o = lock_r; // [R5]
        lock_indicator_pin_oe = 1'b1;
      end
      `PLDL_LD_NCH: begin
        // pulled up outside; drive low only during a pulse
        lock_indicator_pin_o = 1'b0; // [R11]
        lock_indicator_pin_oe = pulse_r;
      end
      `PLDL_LD_PCH: begin
        // pulled down outside; drive high only during a pulse
        lock_indicator_pin_o = 1'b1; // [R11]
        lock_indicator_pin_oe = pulse_r;
      end
      `PLDL_LD_CHARGED: begin
        // unlock shorts the capacitor so any drop restarts the charge
        lock_indicator_pin_o = 1'b0; // [R7]
        lock_indicator_pin_oe = ~lock_r;
      end
      default: begin
        lock_indicator_pin_o = 1'b0;
        lock_indicator_pin_oe = 1'b0;
      end
    endcase
  end
  assign lock_indicator_source_en = (lock_pin_r == `PLDL_LD_CHARGED) & lock_r; // [R7]

  // holdover logic sees the pin level, or high when the comparator is off
  assign holdover_lock_sense = comp_en ? lock_pin_comparator_i : 1'b1; // [R13] [R15]

  // ****************************************
  // output multiplexers and clock gating
  // ****************************************
  assign status_pin = (status_pin_r[7:2] == `PLDL_STS_FLAG) ? lock_r : // [R5]
    (status_pin_r[7:2] == `PLDL_STS_COMP) ? comp_level : 1'b0; // [R9]
  assign reference_monitor_pin = (reference_monitor_pin_pin_r == `PLDL_RMN_FLAG) ? lock_r : // [R5]
    (reference_monitor_pin_pin_r == `PLDL_RMN_COMP) ? comp_level : 1'b0; // [R9]

  // combinational on purpose: the enable follows the comparator without a clock
  genvar g;
  generate
    for (g = 0; g < 16; g = g + 1) begin : gen_gate
      assign clk_out_enable[g] = clk_out_request[g] & (~gate_r[g] | comp_level); // [R10]
    end
  endgenerate

  // ****************************************
  // events and interrupt
  // ****************************************
  wire [`PLDL_EV_W-1:0] ev;
  wire [`PLDL_EV_W-1:0] w1c;
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      comp_q_r <= 1'b0;
    end else begin
      comp_q_r <= comp_level;
    end
  end
  assign ev = {comp_level & ~comp_q_r, lock_clr, lock_set};
  assign w1c = (wr && idx == `PLDL_IDX_IRQ_STAT) ? wb_dat_i[`PLDL_EV_W-1:0] :
    {`PLDL_EV_W{1'b0}};
  assign irq = |(irq_stat_r & irq_mask_r);

  // ****************************************
  // wishbone slave
  // ****************************************
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      status_pin_r <= `PLDL_RST_STATUS_PIN;
      lock_cfg_r <= `PLDL_RST_LOCK_CFG;
      lock_pin_r <= `PLDL_RST_LOCK_PIN;
      reference_monitor_pin_pin_r <= `PLDL_RST_REFERENCE_MONITOR_PIN_PIN;
      comp_ctrl_r <= `PLDL_RST_COMP_CTRL;
      gate_r <= 16'h0000;
      irq_mask_r <= {`PLDL_EV_W{1'b0}};
      irq_stat_r <= {`PLDL_EV_W{1'b0}};
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      // a new event wins over a clear in the same cycle
      irq_stat_r <= (irq_stat_r & ~w1c) | ev;
      if (wr) begin
        case (idx)
          `PLDL_IDX_STATUS_PIN: status_pin_r <= wb_dat_i[7:0];
          `PLDL_IDX_LOCK_CFG: lock_cfg_r <= wb_dat_i[7:0];
          `PLDL_IDX_LOCK_PIN: lock_pin_r <= wb_dat_i[5:0]; // [R8]
          `PLDL_IDX_REFERENCE_MONITOR_PIN_PIN: reference_monitor_pin_pin_r <= wb_dat_i[4:0];
          `PLDL_IDX_COMP_CTRL: comp_ctrl_r <= wb_dat_i[7:0]; // [R8]
          `PLDL_IDX_GATE_LO: gate_r[7:0] <= wb_dat_i[7:0];
          `PLDL_IDX_GATE_HI: gate_r[15:8] <= wb_dat_i[7:0];
          `PLDL_IDX_IRQ_MASK: irq_mask_r <= wb_dat_i[`PLDL_EV_W-1:0];
          default: begin
          end
        endcase
      end
      wb_dat_o <= 32'h0000_0000;
      if (req && !wb_we_i) begin
        case (idx)
          `PLDL_IDX_STATUS_PIN: wb_dat_o <= {24'h00_0000, status_pin_r};
          `PLDL_IDX_LOCK_CFG: wb_dat_o <= {24'h00_0000, lock_cfg_r};
          `PLDL_IDX_LOCK_PIN: wb_dat_o <= {26'h000_0000, lock_pin_r};
          `PLDL_IDX_REFERENCE_MONITOR_PIN_PIN: wb_dat_o <= {27'h000_0000, reference_monitor_pin_pin_r};
          `PLDL_IDX_COMP_CTRL: wb_dat_o <= {24'h00_0000, comp_ctrl_r};
          `PLDL_IDX_GATE_LO: wb_dat_o <= {24'h00_0000, gate_r[7:0]};
          `PLDL_IDX_GATE_HI: wb_dat_o <= {24'h00_0000, gate_r[15:8]};
          `PLDL_IDX_IRQ_STAT: wb_dat_o <= {29'h0000_0000, irq_stat_r};
          `PLDL_IDX_IRQ_MASK: wb_dat_o <= {29'h0000_0000, irq_mask_r};
          `PLDL_IDX_LIVE: wb_dat_o <= {16'h0000, good_cnt_r, 4'h0, lock_indicator_pin_i,
            holdover_lock_sense, comp_level, lock_r};
          default: wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule // pldl_lock_detect
`default_nettype wire

// ===== verif/pldl_lock_detect_props.sv
// assertion checker for the lock detect block
`timescale 1ns/1ps
`default_nettype none
module pldl_lock_detect_props (
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic phase_edge_comparator_strobe,
  input wire logic [7:0] phase_edge_comparator_error,
  input wire logic lock_pin_comparator_i,
  input wire logic lock_indicator_source_en,
  input wire logic holdover_lock_sense,
  input wire logic [15:0] clk_out_request,
  input wire logic [15:0] clk_out_enable,
  input wire logic phase_lock_flag
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  // ****
  // good-cycle run
  // ****
  // widest lock window of any setting, so the run never undercounts
  wire logic good = phase_edge_comparator_error < 8'h20;
  logic [8:0] run_r;
  always_ff @(posedge ref_clk or negedge reset_n)
    if (!reset_n) run_r <= 9'h000;
    else if (phase_edge_comparator_strobe) run_r <= good ? run_r + 9'h001 : 9'h000;
  // ****
  // properties
  // ****
  AST_ACK_NEXT:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack");
  AST_ACK_ONE:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  AST_LOCK_RUN:
    assert property ($rose(phase_lock_flag) |-> $past(phase_edge_comparator_strobe)
      && $past(good) && $past(run_r) >= 9'h004) else $error("early lock");
  AST_UNLOCK:
    assert property (phase_lock_flag && phase_edge_comparator_strobe
      && phase_edge_comparator_error > 8'h40 |=> !phase_lock_flag) else $error("no unlock");
  AST_FLAG_HOLD:
    assert property (!phase_edge_comparator_strobe |=> $stable(phase_lock_flag))
    else $error("flag moved");
  AST_SRC:
    assert property (lock_indicator_source_en |-> phase_lock_flag) else $error("bad source");
  AST_SENSE:
    assert property (!holdover_lock_sense |-> !lock_pin_comparator_i) else $error("bad sense");
  AST_GATE:
    assert property ((clk_out_enable & ~clk_out_request) == 16'h0000) else $error("bad gate");
endmodule // pldl_lock_detect_props
bind pldl_lock_detect pldl_lock_detect_props u_props (
  .ref_clk, .reset_n, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .phase_edge_comparator_strobe,
  .phase_edge_comparator_error, .lock_pin_comparator_i, .lock_indicator_source_en,
  .holdover_lock_sense, .clk_out_request, .clk_out_enable, .phase_lock_flag
);
`default_nettype wire

// ===== verif/pldl_lock_detect_tb.sv
// self-checking testbench for the lock detect block
`timescale 1ns/1ps
`default_nettype none
`include "pldl_regs.vh"
module pldl_lock_detect_tb;
  logic clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, stro = 1'b0, cmp = 1'b0;
  logic [3:0] sel = 4'h0, sl = 4'h1;
  logic pu = 1'b0;
  logic [11:0] adr = 12'h000;
  logic [31:0] wd = 32'h0000_0000, rdat;
  logic [7:0] err = 8'h00;
  logic [15:0] req = 16'hFFFF;
  wire logic [31:0] dat;
  wire logic [15:0] cen;
  wire logic ack, po, poe, src, sts, rmn, hs, flag, irq;
  // released pin settles to the outside pull level chosen by the bench
  wire logic pin = poe ? po : pu;
  int n_fail = 0, tests_run = 0, seed = 81, th, nd, cnt = 0, lk = 0;
  int need[4] = '{5, 16, 64, 255};
  int thr[4] = '{16, 8, 32, 16};
  pldl_lock_detect dut (.ref_clk(clk), .reset_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(dat),
    .wb_ack_o(ack), .phase_edge_comparator_strobe(stro), .phase_edge_comparator_error(err),
    .lock_indicator_pin_i(pin), .lock_indicator_pin_o(po), .lock_indicator_pin_oe(poe),
    .lock_indicator_source_en(src), .lock_pin_comparator_i(cmp), .status_pin(sts),
    .reference_monitor_pin(rmn), .holdover_lock_sense(hs), .clk_out_request(req),
    .clk_out_enable(cen), .phase_lock_flag(flag), .irq(irq));
  always #25 clk = ~clk;
  // ****
  // tasks
  // ****
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wb(input logic w, input logic [9:0] i, input logic [7:0] d);
    @(posedge clk);
    {cyc, stb, we, adr, sel, wd} <= {2'b11, w, i, 2'b00, sl, 24'h00_0000, d};
    while (ack !== 1'b1) @(posedge clk);
    rdat = dat;
    {cyc, stb} <= 2'b00;
  endtask
  task automatic rd(input logic [9:0] i, input logic [7:0] e);
    wb(1'b0, i, 8'h00);
    chk("register", {24'h00_0000, e}, rdat);
  endtask
  // model: run of good strobes while unlocked, one bad strobe unlocks
  task automatic pulse(input int e);
    // errors stay far below one comparator period of the bench clock
    {stro, err} <= {1'b1, e[7:0]};
    @(posedge clk);
    stro <= 1'b0;
    if (e < th) begin
      cnt++;
      if (cnt >= nd) lk = 1;
    end else if (e > 2 * th) begin
      cnt = 0;
      lk = 0;
    end else if (lk == 0) cnt = 0;
    #1 chk("lock flag", lk, flag);
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // ****
  // main sequence
  // ****
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    conclude();
  end
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rd(`PLDL_IDX_LIVE, 8'h04);
    wb(1'b1, 10'h3FF, 8'hFF);
    rd(10'h3FF, 8'h00);
    // a write without the low byte lane selected must be ignored
    sl = 4'h2;
    wb(1'b1, `PLDL_IDX_LOCK_CFG, 8'h7F);
    sl = 4'h1;
    rd(`PLDL_IDX_LOCK_CFG, 8'h00);
    wb(1'b1, `PLDL_IDX_LOCK_PIN, 8'h01);
    wb(1'b1, `PLDL_IDX_REFERENCE_MONITOR_PIN_PIN, 8'h01);
    for (int i = 0; i < 4; i++) begin
      th = thr[i] >> (i % 2);
      nd = need[i];
      wb(1'b1, `PLDL_IDX_STATUS_PIN, {6'h01, i[1:0]});
      wb(1'b1, `PLDL_IDX_LOCK_CFG, {1'b0, i[1:0], i[0], 4'h0});
      rd(`PLDL_IDX_LOCK_CFG, {1'b0, i[1:0], i[0], 4'h0});
      // a between-window strobe one short of lock must restart the run
      for (int k = 1; k < 2 * nd; k++) pulse(k == nd ? th : {$random(seed)} % th);
      pulse(0);
      chk("status", 1, sts);
      chk("monitor", 1, rmn);
      chk("indicator", 2'b11, {poe, po});
      rd(`PLDL_IDX_LIVE, 8'h0D);
      pulse(2 * th);
      pulse(2 * th + 1);
      chk("status", 0, sts);
    end
    chk("irq", 0, irq);
    rd(`PLDL_IDX_IRQ_STAT, 8'h03);
    wb(1'b1, `PLDL_IDX_IRQ_MASK, 8'h01);
    chk("irq", 1, irq);
    wb(1'b1, `PLDL_IDX_IRQ_STAT, 8'h01);
    chk("irq", 0, irq);
    // pulsed modes: a between-window strobe gives one drive pulse
    wb(1'b1, `PLDL_IDX_LOCK_PIN, 8'h02);
    pu <= 1'b1;
    pulse(th);
    chk("n-channel", 2'b10, {poe, pin});
    @(posedge clk);
    #1 chk("n-channel", 2'b01, {poe, pin});
    wb(1'b1, `PLDL_IDX_LOCK_PIN, 8'h03);
    pu <= 1'b0;
    pulse(th + 1);
    chk("p-channel", 2'b11, {poe, pin});
    @(posedge clk);
    #1 chk("p-channel", 2'b00, {poe, pin});
    th = 16;
    nd = 5;
    wb(1'b1, `PLDL_IDX_STATUS_PIN, 8'h08);
    wb(1'b1, `PLDL_IDX_LOCK_CFG, 8'h00);
    wb(1'b1, `PLDL_IDX_LOCK_PIN, 8'h04);
    wb(1'b1, `PLDL_IDX_REFERENCE_MONITOR_PIN_PIN, 8'h02);
    req <= 16'($random(seed));
    wb(1'b1, `PLDL_IDX_COMP_CTRL, 8'h08);
    wb(1'b1, `PLDL_IDX_GATE_HI, 8'hFF);
    chk("pin", 3'b100, {poe, po, src});
    chk("sense", 0, hs);
    chk("gated", req & 16'h00FF, cen);
    repeat (5) pulse(1);
    chk("source", 1, src);
    cmp <= 1'b1;
    @(posedge clk);
    #1 chk("comparator", 3'b111, {sts, rmn, hs});
    chk("gated", req, cen);
    pulse(33);
    chk("pin", 3'b100, {poe, po, src});
    rd(`PLDL_IDX_IRQ_STAT, 8'h07);
    cmp <= 1'b0;
    wb(1'b1, `PLDL_IDX_COMP_CTRL, 8'h00);
    chk("sense", 1, hs);
    conclude();
  end
endmodule // pldl_lock_detect_tb
`default_nettype wire
